// ==== src/rlsc_top.sv ====
// Purpose: Receive lane status: word lock, bad block type, misalignment and multi-use bits.
// Assumes: Lane words arrive already crossed into the core clock domain, one word per lane per cycle.
// Notes: All outputs are registered on CLK_I; there is one bit per lane for each lane indication.
`timescale 1ns/1ns
module rlsc_top #(
	parameter int LANES = 4
) (
	input wire logic CLK_I,
	input wire logic RESETN_I,
	input wire logic [LANES-1:0] RX_VALID_I,
	input wire logic [LANES*rlsc_pkg::WORD_W-1:0] RX_WORD_I,
	input wire logic [LANES-1:0] RX_ACTIVE_I,
	output logic RX_MISALIGNED_O,
	output logic [LANES-1:0] RX_BAD_TYPE_O,
	output logic [7:0] RX_MUBITS_O,
	output logic RX_MUBITS_UPDATED_O,
	output logic [LANES-1:0] RX_WORD_LOCK_O
);
	// Lane count must fit the per-lane word bus and be non-empty.
	if (LANES < 1 || LANES > 24) begin : g_bad_lanes
		$error("LANES must be between 1 and 24");
	end

	typedef struct packed {
		logic [7:0] mu;
		logic upd;
		logic mis;
	} rlsc_top_t;

	rlsc_top_t st_ff;
	rlsc_top_t nxt_st;
	logic [LANES-1:0] lane_sync;
	logic [LANES-1:0] lane_seen;
	logic [LANES-1:0] lane_ctrl;
	logic [LANES*8-1:0] lane_mu;
	logic all_seen;
	logic any_ctrl;
	logic [7:0] sel_mu;

	// Picks the multi-use field of the highest lane carrying a burst or idle control word.
	function automatic logic [7:0] rlsc_pick_mu(input logic [LANES-1:0] ctrl, input logic [LANES*8-1:0] mu);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < LANES; i++) begin
			if (ctrl[i]) begin
				r = mu[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// One checker per lane; shared recovered clocks upstream make no difference here.
	for (genvar g = 0; g < LANES; g++) begin : g_lane
		logic [rlsc_pkg::WORD_W-1:0] w;
		assign w = RX_WORD_I[g*rlsc_pkg::WORD_W +: rlsc_pkg::WORD_W];
		assign lane_ctrl[g] = RX_VALID_I[g] && RX_WORD_LOCK_O[g]
			&& w[rlsc_pkg::HDR_LO+1:rlsc_pkg::HDR_LO] == rlsc_pkg::HDR_CTRL && w[rlsc_pkg::CTRL_BIT];
		assign lane_mu[g*8 +: 8] = w[rlsc_pkg::MU_HI:rlsc_pkg::MU_LO];
		rlsc_lane u_lane (
			.clk_i(CLK_I),
			.resetn_i(RESETN_I),
			.valid_i(RX_VALID_I[g]),
			.word_i(w),
			.lock_o(RX_WORD_LOCK_O[g]),
			.sync_o(lane_sync[g]),
			.seen_o(lane_seen[g]),
			.bad_type_o(RX_BAD_TYPE_O[g])
		);
	end

	// Inactive lanes count as seen and as carrying sync so they never trip the aligner.
	assign all_seen = &(lane_seen | ~RX_ACTIVE_I);
	assign any_ctrl = |lane_ctrl;
	assign sel_mu = rlsc_pick_mu(lane_ctrl, lane_mu);

	// Next state of the aggregate status.
	always_comb begin
		nxt_st = st_ff;
		nxt_st.upd = 1'b0;
		nxt_st.mis = 1'b0;
		if (any_ctrl) begin
			nxt_st.mu = sel_mu;
			nxt_st.upd = sel_mu != st_ff.mu;
		end
		// Sync on some active lanes but not all means the lanes have slipped apart.
		if (all_seen && |(lane_sync & RX_ACTIVE_I) && !(&(lane_sync | ~RX_ACTIVE_I))) begin
			nxt_st.mis = 1'b1;
		end
	end

	// Single core-clock register for all aggregate status.
	// No transmit path lives here, so nothing is sourced from a transmit reference clock.
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			st_ff <= '0;
			st_ff.mu <= rlsc_pkg::MU_RESET;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign RX_MISALIGNED_O = st_ff.mis;
	assign RX_MUBITS_O = st_ff.mu;
	assign RX_MUBITS_UPDATED_O = st_ff.upd;

	// The strobe marks a real change of the multi-use bits.
	chk_mu_pulse: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		RX_MUBITS_UPDATED_O |-> RX_MUBITS_O != $past(RX_MUBITS_O))
		else $error("mubits strobe without change");
	// Every change of the bits is strobed in the same cycle.
	chk_mu_change: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		$changed(RX_MUBITS_O) |-> RX_MUBITS_UPDATED_O)
		else $error("mubits changed without strobe");
	// A control word loads its field one cycle later.
	chk_mu_value: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		any_ctrl |=> RX_MUBITS_O == $past(sel_mu))
		else $error("mubits not taken from control word");
	// No misalignment before every active lane has shown a sync word.
	chk_mis_gate: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		!all_seen |=> !RX_MISALIGNED_O)
		else $error("misaligned before sync seen");
	// Partial sync after all lanes were seen raises misalignment.
	chk_mis_raise: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		all_seen && |(lane_sync & RX_ACTIVE_I) && !(&(lane_sync | ~RX_ACTIVE_I)) |=> RX_MISALIGNED_O)
		else $error("missed misalignment");
endmodule // rlsc_top

// ==== src/rlsc_pkg.sv ====
// Purpose: Shared constants for the receive lane status block.
// Assumes: Each lane delivers one 67-bit word per core clock with its sync header in bits 65:64.
// Notes: Block type codes are kept here so lane checker and bench agree.
package rlsc_pkg;
	// Word layout of one received lane word.
	localparam int WORD_W = 67;
	localparam int HDR_LO = 64;
	localparam int CTRL_BIT = 63;
	localparam int TYPE_HI = 63;
	localparam int TYPE_LO = 58;
	localparam int MU_HI = 31;
	localparam int MU_LO = 24;
	// Sync header encodings: data and control.
	localparam logic [1:0] HDR_DATA = 2'h1;
	localparam logic [1:0] HDR_CTRL = 2'h2;
	// Consecutive good headers needed for word lock.
	localparam int LOCK_COUNT = 64;
	localparam int CNT_W = 7;
	// Meta-frame control word block types (bit 63 clear).
	localparam logic [5:0] TYPE_SYNC = 6'h1E;
	localparam logic [5:0] TYPE_SCRAM = 6'h0A;
	localparam logic [5:0] TYPE_SKIP = 6'h07;
	localparam logic [5:0] TYPE_DIAG = 6'h19;
	// Reset values.
	localparam logic [7:0] MU_RESET = 8'h00;
endpackage

// ==== src/rlsc_lane.sv ====
// Purpose: Per-lane word lock, meta-frame sync detection and block type check.
// Assumes: Lane word is already in the core clock domain and sampled when valid.
// Notes: Lock is derived from sync headers only, never from meta-frame words.
`timescale 1ns/1ns
module rlsc_lane (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic valid_i,
	input wire logic [rlsc_pkg::WORD_W-1:0] word_i,
	output logic lock_o,
	output logic sync_o,
	output logic seen_o,
	output logic bad_type_o
);
	typedef struct packed {
		logic [rlsc_pkg::CNT_W-1:0] cnt;
		logic lock;
		logic sync;
		logic seen;
		logic bad;
	} rlsc_lane_t;

	rlsc_lane_t st_ff;
	rlsc_lane_t nxt_st;
	logic [1:0] hdr;
	logic [5:0] btype;
	logic hdr_ok;
	logic mf_word;

	// Header and block type fields of the current word.
	assign hdr = word_i[rlsc_pkg::HDR_LO+1:rlsc_pkg::HDR_LO];
	assign btype = word_i[rlsc_pkg::TYPE_HI:rlsc_pkg::TYPE_LO];
	assign hdr_ok = (hdr == rlsc_pkg::HDR_DATA) || (hdr == rlsc_pkg::HDR_CTRL);
	assign mf_word = valid_i && hdr == rlsc_pkg::HDR_CTRL && !word_i[rlsc_pkg::CTRL_BIT];

	// Next state; a bad header restarts the lock hunt from zero.
	always_comb begin
		nxt_st = st_ff;
		nxt_st.sync = 1'b0;
		nxt_st.bad = 1'b0;
		if (valid_i) begin
			if (!hdr_ok) begin
				nxt_st.cnt = '0;
				nxt_st.lock = 1'b0;
			end else if (!st_ff.lock) begin
				nxt_st.cnt = st_ff.cnt + 1'b1;
				if (nxt_st.cnt == rlsc_pkg::CNT_W'(rlsc_pkg::LOCK_COUNT)) begin
					nxt_st.lock = 1'b1;
				end
			end
		end
		// Meta-frame words are only judged once the word boundary is trusted.
		if (mf_word && st_ff.lock) begin
			if (btype == rlsc_pkg::TYPE_SYNC) begin
				nxt_st.sync = 1'b1;
				nxt_st.seen = 1'b1;
			end else if (btype != rlsc_pkg::TYPE_SCRAM && btype != rlsc_pkg::TYPE_SKIP
				&& btype != rlsc_pkg::TYPE_DIAG) begin
				nxt_st.bad = 1'b1;
			end
		end
	end

	// State register.
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign lock_o = st_ff.lock;
	assign sync_o = st_ff.sync;
	assign seen_o = st_ff.seen;
	assign bad_type_o = st_ff.bad;

	// Lock rises only on the 64th consecutive good header.
	chk_lock_count: assert property (@(posedge clk_i) disable iff (!resetn_i)
		$rose(st_ff.lock) |-> st_ff.cnt == 7'h40 && $past(st_ff.cnt) == 7'h3F)
		else $error("lock rose without 64 good headers");
	// A bad header drops lock on the next edge.
	chk_lock_drop: assert property (@(posedge clk_i) disable iff (!resetn_i)
		valid_i && !hdr_ok |=> !st_ff.lock && st_ff.cnt == 7'h00)
		else $error("lock kept after a bad header");
	// Illegal meta-frame type flags the lane for one cycle.
	chk_bad_type: assert property (@(posedge clk_i) disable iff (!resetn_i)
		mf_word && st_ff.lock && btype != 6'h1E && btype != 6'h0A && btype != 6'h07
		&& btype != 6'h19 |=> st_ff.bad)
		else $error("illegal block type not flagged");
	// Sync seen never falls back before reset.
	chk_seen_sticky: assert property (@(posedge clk_i) disable iff (!resetn_i)
		st_ff.seen |=> st_ff.seen)
		else $error("sync seen flag cleared");
endmodule // rlsc_lane

// ==== tb/rlsc_peer.sv ====
// Purpose: Far-end lane source feeding words into the status block.
// Assumes: One word per lane per core clock, already crossed.
// Notes: A released lane shows the inverse of its last word.
`timescale 1ns/1ns
module rlsc_peer #(
	parameter int L = 4
) (
	input wire logic clk_i,
	input wire logic [L-1:0] en_i,
	input wire logic [rlsc_pkg::WORD_W-1:0] w_i,
	output logic [L-1:0] valid_o,
	output logic [L*rlsc_pkg::WORD_W-1:0] word_o
);
	localparam int W = rlsc_pkg::WORD_W;
	// All lanes share the one source clock, so their rates match.
	initial valid_o = '0;
	initial word_o = '0;
	// Idle lanes toggle, so a stale word never passes for a fresh one.
	always @(posedge clk_i) begin
		for (int g = 0; g < L; g++) begin
			valid_o[g] <= en_i[g];
			word_o[g*W+:W] <= en_i[g] ? w_i : ~word_o[g*W+:W];
		end
	end
endmodule // rlsc_peer

// ==== tb/rx_lane_status_and_clocking_test.sv ====
// Purpose: Self-checking bench for the receive lane status block.
// Assumes: Outputs follow the taking edge by one cycle, except misaligned, which follows by two.
// Notes: Every word passes through the far-end model first.
`timescale 1ns/1ns
module rx_lane_status_and_clocking_test;
	localparam int L = 4;
	logic clk, rstn, mis, upd;
	logic [L-1:0] en, act, vld, lock, bad;
	logic [66:0] wi;
	logic [L*67-1:0] wd;
	logic [7:0] mu;
	int num_errors, cmp_count;
	rlsc_peer #(.L(L)) peer (.clk_i(clk), .en_i(en), .w_i(wi), .valid_o(vld), .word_o(wd));
	rlsc_top #(.LANES(L)) dut (.CLK_I(clk), .RESETN_I(rstn), .RX_VALID_I(vld), .RX_WORD_I(wd),
		.RX_ACTIVE_I(act), .RX_MISALIGNED_O(mis), .RX_BAD_TYPE_O(bad), .RX_MUBITS_O(mu),
		.RX_MUBITS_UPDATED_O(upd), .RX_WORD_LOCK_O(lock));
	// Free-running core clock.
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end
	// Word builders: meta-frame and control words.
	function automatic logic [66:0] mf(input logic [5:0] t);
		return {3'h2, t, 58'h0};
	endfunction
	function automatic logic [66:0] cw(input logic [7:0] m);
		return {3'h2, 1'h1, 31'h0, m, 24'h0};
	endfunction
	// Offer one word on the masked lanes for one cycle.
	task automatic put(input logic [L-1:0] m, input logic [66:0] w);
		@(posedge clk);
		en <= m;
		wi <= w;
	endtask
	// Release the lanes and settle after the answer edge.
	task automatic fin();
		@(posedge clk);
		en <= '0;
		@(posedge clk);
		#1;
	endtask
	task automatic nx();
		@(posedge clk);
		#1;
	endtask
	task automatic cmp(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("Error %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic conclude();
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Main sequence.
	initial begin
		en = '0;
		wi = '0;
		act = '1;
		rstn = 1'h0;
		num_errors = 0;
		cmp_count = 0;
		repeat (3) @(posedge clk);
		rstn <= 1'h1;
		nx();
		cmp(lock, 8'h0); cmp(mis, 8'h0); cmp(mu, 8'h0); cmp(upd, 8'h0); cmp(bad, 8'h0);
		repeat (63) put('1, {3'h1, 64'h0});
		fin();
		cmp(lock, 8'h0);
		put(4'h7, {3'h1, 64'h0});
		fin();
		cmp(lock, 8'h7);
		put(4'h8, {3'h1, 64'h0});
		fin();
		cmp(lock, 8'hF);
		put(4'h2, 67'h0);
		fin();
		cmp(lock, 8'hD);
		repeat (64) put(4'h2, {3'h1, 64'h0});
		fin();
		cmp(lock, 8'hF);
		put(4'h1, mf(rlsc_pkg::TYPE_SYNC));
		fin();
		cmp(mis, 8'h0);
		put('1, mf(rlsc_pkg::TYPE_SCRAM)); put('1, mf(rlsc_pkg::TYPE_SKIP)); put('1, mf(rlsc_pkg::TYPE_DIAG));
		put('1, mf(rlsc_pkg::TYPE_SYNC));
		fin();
		cmp(bad, 8'h0); cmp(mis, 8'h0); cmp(lock, 8'hF);
		put(4'h4, mf(6'h01));
		fin();
		cmp(bad, 8'h4);
		nx();
		cmp(bad, 8'h0);
		put(4'h1, mf(rlsc_pkg::TYPE_SYNC));
		fin();
		// Misaligned passes the lane register and then the aggregate register, so it trails by two edges.
		cmp(mis, 8'h0);
		nx();
		cmp(mis, 8'h1);
		nx();
		cmp(mis, 8'h0);
		act <= 4'h1;
		put(4'h1, mf(rlsc_pkg::TYPE_SYNC));
		fin();
		cmp(mis, 8'h0);
		nx();
		cmp(mis, 8'h0);
		put(4'h1, cw(8'hA5));
		fin();
		cmp(mu, 8'hA5); cmp(upd, 8'h1);
		nx();
		cmp(upd, 8'h0);
		put(4'h2, cw(8'hA5));
		fin();
		cmp(mu, 8'hA5); cmp(upd, 8'h0);
		put(4'h1, cw(8'h11));
		put(4'h1, cw(8'h22));
		fin();
		cmp(mu, 8'h22); cmp(upd, 8'h1);
		put(4'h2, 67'h0);
		put(4'h2, cw(8'h77));
		fin();
		cmp(mu, 8'h22); cmp(lock, 8'hD);
		conclude();
	end
endmodule // rx_lane_status_and_clocking_test
